// ---- hw/psb_defines.svh ----
// psb_defines.svh: bit positions, codes and offsets of the sideband packer
// assumes inclusion by bare name; definitions only
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH
// raw transmit word fields
`define PSB_TX_W          80
`define PSB_TX_B0         0
`define PSB_TX_B1         11
`define PSB_TX_B2         40
`define PSB_TX_B3         49
`define PSB_TX_K0         8
`define PSB_TX_K1         19
`define PSB_TX_K2         48
`define PSB_TX_K3         57
`define PSB_TX_COMPL      9
`define PSB_TX_EIDLE      10
`define PSB_TX_DETLB      20
`define PSB_TX_PWR_LO     21
`define PSB_TX_MARGIN_LO  23
`define PSB_TX_DEEMPH     26
`define PSB_TX_SWING      27
`define PSB_TX_SYNC_LO    28
`define PSB_TX_BLKST      30
`define PSB_TX_DVALID     31
`define PSB_TX_RATE_LO    32
`define PSB_TX_POLAR      34
`define PSB_TX_EQEVAL     35
`define PSB_TX_EQACT      36
`define PSB_TX_EQOOR      37
`define PSB_TX_HINT_LO    58
`define PSB_TX_COEF_LO    61
// raw receive word fields
`define PSB_RX_W          66
`define PSB_RX_B0         0
`define PSB_RX_B1         15
`define PSB_RX_B2         40
`define PSB_RX_B3         55
`define PSB_RX_K0         8
`define PSB_RX_K1         23
`define PSB_RX_K2         48
`define PSB_RX_K3         63
`define PSB_RX_SY0        10
`define PSB_RX_SY1        25
`define PSB_RX_SY2        50
`define PSB_RX_SY3        65
`define PSB_RX_SYNC_LO    30
`define PSB_RX_PHYST      32
`define PSB_RX_VALID      33
`define PSB_RX_STAT_LO    34
`define PSB_RX_BLKST      37
`define PSB_RX_DVALID     38
// receive status codes
`define PSB_ST_OK         3'h0
`define PSB_ST_SKPADD     3'h1
`define PSB_ST_SKPDEL     3'h2
`define PSB_ST_RXDET      3'h3
`define PSB_ST_DECERR     3'h4
`define PSB_ST_OVFL       3'h5
`define PSB_ST_UDFL       3'h6
`define PSB_ST_DISP       3'h7
// register byte offsets
`define PSB_A_CTRL        8'h00
`define PSB_A_TXD         8'h04
`define PSB_A_EQ          8'h08
`define PSB_A_RXD         8'h0c
`define PSB_A_STAT        8'h10
`define PSB_A_RATE        8'h14
`endif

// ---- hw/psb_host.sv ----
// psb_host.sv: fabric-side controller packing the raw transceiver sideband
// assumes raw rx word and pll status arrive asynchronously; ahb-lite slave
//
// Summary of operation
// - tx bytes and k flags at mapped bits
// - compliance 9, idle 10, detect 20
// - power 22:21, margin 25:23, swing 27
// - rate 33:32, polarity 34
// - gen2 de-emphasis bit 26 only doubled
// - gen3 sync 29:28, start 30, valid 31
// - gen3 eq eval 35, active 36, oor 37
// - gen3 hint 60:58, coefficients 78:61
// - coefficients pre, main, post cursor order
// - bonded gen2/3 request drives pll control
// - pll done returns to channel done
// - calibration busy is or of both
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`include "psb_defines.svh"
module psb_host
   import psb_pkg::*;
(
   input  wire logic                 i_ref_clk,    // 25 MHz clock
   input  wire logic                 i_reset_n,    // sync reset, low
   input  wire logic [31:0]          i_haddr,      // ahb address
   input  wire logic [1:0]           i_htrans,     // ahb transfer type
   input  wire logic                 i_hwrite,     // ahb write
   input  wire logic [2:0]           i_hsize,      // ahb size
   input  wire logic [31:0]          i_hwdata,     // ahb write data
   input  wire logic                 i_hsel,       // ahb select
   input  wire logic                 i_hready,     // ahb bus ready
   output logic      [31:0]          o_hrdata,     // ahb read data
   output logic                      o_hreadyout,  // always ready
   output logic                      o_hresp,      // always okay
   output logic      [`PSB_TX_W-1:0] o_tx_raw,     // raw transmit word
   input  wire logic [`PSB_RX_W-1:0] i_rx_raw,     // raw receive word
   output logic      [1:0]           o_rate_change_request, // to pll control
   input  wire logic [1:0]           i_rate_change_complete_in, // pll done
   input  wire logic                 i_pll_locked, // pll lock, async
   input  wire logic                 i_pll_cal_busy, // pll calibration
   input  wire logic                 i_tx_cal_busy,  // channel calibration
   output logic                      o_cal_busy,   // or of both busies
   output logic                      o_bond_clk_en // bonding bus enable
);
   // control registers
   psb_mode_t  mode, next_mode;
   logic       bonded, next_bonded;
   logic [4:0] lanes_log2, next_lanes_log2;
   logic [31:0] txd, next_txd;
   logic [3:0]  txk, next_txk;
   psb_txctl_t ctl, next_ctl;
   psb_eq_t    eq, next_eq;
   logic [1:0] sw_target, next_sw_target;
   psb_sw_st_t sw_st, next_sw_st;
   logic       sw_err, next_sw_err;
   logic [`PSB_TX_W-1:0] next_tx_raw;
   logic [1:0] next_req;
   logic [31:0] next_hrdata;
   // ahb address phase capture
   logic       ap_wr, next_ap_wr;
   logic [7:0] ap_addr, next_ap_addr;

   // asynchronous inputs through three flops; second and third agree
   localparam int SW = `PSB_RX_W + 5;
   logic [SW-1:0] s1, s2, s3, rx_q, next_rx_q;
   always_ff @(posedge i_ref_clk) begin
      s1 <= {i_rx_raw, i_rate_change_complete_in, i_pll_locked, i_pll_cal_busy,
             i_tx_cal_busy};
      s2 <= s1;
      s3 <= s2;
   end
   // per-bit filter: hold until stable; generate over each bit
   genvar gi;
   generate
      for (gi = 0; gi < SW; gi++) begin : g_flt
         always_comb next_rx_q[gi] = (s2[gi] == s3[gi]) ? s3[gi] : rx_q[gi];
      end
   endgenerate
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) rx_q <= '0;
      else rx_q <= next_rx_q;
   end
   logic [`PSB_RX_W-1:0] rxw;
   logic [1:0] done_q;
   logic lock_q, pcal_q, tcal_q;
   assign {rxw, done_q, lock_q, pcal_q, tcal_q} = rx_q;

   // receive unpack, unassigned bits ignored per mode
   psb_rxst_t rs;
   always_comb begin
      rs = '0;
      rs.sync_ok[0] = rxw[`PSB_RX_SY0];
      rs.phy_status = rxw[`PSB_RX_PHYST];
      rs.rx_valid   = rxw[`PSB_RX_VALID];
      rs.status     = rxw[`PSB_RX_STAT_LO +: 3];
      if (mode != PSB_G1_X1) rs.sync_ok[1] = rxw[`PSB_RX_SY1];
      if (mode == PSB_G3) begin
         rs.sync_ok[3:2] = {rxw[`PSB_RX_SY3], rxw[`PSB_RX_SY2]};
         rs.sync   = rxw[`PSB_RX_SYNC_LO +: 2];
         rs.blkst  = rxw[`PSB_RX_BLKST];
         rs.dvalid = rxw[`PSB_RX_DVALID];
      end
   end
   logic [31:0] rxd;
   logic [3:0]  rxk;
   always_comb begin
      rxd = '0;
      rxk = '0;
      rxd[7:0] = rxw[`PSB_RX_B0 +: 8];
      rxk[0]   = rxw[`PSB_RX_K0];
      if (mode != PSB_G1_X1) begin
         rxd[15:8] = rxw[`PSB_RX_B1 +: 8];
         rxk[1]    = rxw[`PSB_RX_K1];
      end
      if (mode == PSB_G3) begin
         rxd[31:16] = {rxw[`PSB_RX_B3 +: 8], rxw[`PSB_RX_B2 +: 8]};
         rxk[3:2]   = {rxw[`PSB_RX_K3], rxw[`PSB_RX_K2]};
      end
   end

   // transmit pack; bits outside the mode stay zero
   always_comb begin
      next_tx_raw = '0;
      next_tx_raw[`PSB_TX_B0 +: 8] = txd[7:0];
      next_tx_raw[`PSB_TX_K0]      = txk[0];
      next_tx_raw[`PSB_TX_COMPL]   = ctl.compl;
      next_tx_raw[`PSB_TX_EIDLE]   = ctl.eidle;
      next_tx_raw[`PSB_TX_DETLB]   = ctl.detlb;
      next_tx_raw[`PSB_TX_PWR_LO +: 2]    = ctl.pwr;
      next_tx_raw[`PSB_TX_MARGIN_LO +: 3] = ctl.margin;
      next_tx_raw[`PSB_TX_SWING]   = ctl.swing;
      next_tx_raw[`PSB_TX_RATE_LO +: 2]   = ctl.rate;
      next_tx_raw[`PSB_TX_POLAR]   = ctl.polar;
      if (mode != PSB_G1_X1) begin
         next_tx_raw[`PSB_TX_B1 +: 8] = txd[15:8];
         next_tx_raw[`PSB_TX_K1]      = txk[1];
      end
      if (mode == PSB_G12_X2) next_tx_raw[`PSB_TX_DEEMPH] = ctl.deemph;
      if (mode == PSB_G3) begin
         next_tx_raw[`PSB_TX_B2 +: 8] = txd[23:16];
         next_tx_raw[`PSB_TX_B3 +: 8] = txd[31:24];
         next_tx_raw[`PSB_TX_K2]      = txk[2];
         next_tx_raw[`PSB_TX_K3]      = txk[3];
         next_tx_raw[`PSB_TX_SYNC_LO +: 2] = eq.sync;
         next_tx_raw[`PSB_TX_BLKST]   = eq.blkst;
         next_tx_raw[`PSB_TX_DVALID]  = eq.dvalid;
         next_tx_raw[`PSB_TX_EQEVAL]  = eq.eval;
         next_tx_raw[`PSB_TX_EQACT]   = eq.active;
         next_tx_raw[`PSB_TX_EQOOR]   = eq.oor;
         next_tx_raw[`PSB_TX_HINT_LO +: 3]  = eq.hint;
         next_tx_raw[`PSB_TX_COEF_LO +: 18] = eq.coef;
      end
   end

   // rate switch handshake: only bonded and not gen1 uses the pll path
   logic sw_go;
   assign sw_go = ap_wr && (ap_addr == `PSB_A_RATE);
   always_comb begin
      next_sw_st     = sw_st;
      next_sw_target = sw_target;
      next_sw_err    = sw_err;
      next_req       = o_rate_change_request;
      case (sw_st)
         PSB_SW_IDLE: begin
            if (sw_go) begin
               // gen1 has no rate switch path; refused and flagged
               if (bonded && i_hwdata[1:0] != 2'h0) begin
                  next_sw_target = i_hwdata[1:0];
                  next_req       = i_hwdata[1:0];
                  next_sw_st     = PSB_SW_WAIT;
                  next_sw_err    = 1'b0;
               end else begin
                  next_sw_err = 1'b1;
               end
            end
         end
         PSB_SW_WAIT: begin
            if (done_q == sw_target) begin
               next_req   = 2'h0;
               next_sw_st = PSB_SW_IDLE;
            end
         end
         default: next_sw_st = PSB_SW_IDLE;
      endcase
   end

   // register writes in the data phase
   always_comb begin
      next_mode = mode;
      next_bonded = bonded;
      next_lanes_log2 = lanes_log2;
      next_txd = txd;
      next_txk = txk;
      next_ctl = ctl;
      next_eq = eq;
      if (ap_wr) begin
         case (ap_addr)
            `PSB_A_CTRL: begin
               next_mode       = psb_mode_t'(i_hwdata[1:0]);
               next_bonded     = i_hwdata[2];
               next_lanes_log2 = i_hwdata[7:3];
               next_ctl        = psb_txctl_t'(i_hwdata[28:16]);
            end
            `PSB_A_TXD: begin
               next_txd = i_hwdata;
               next_txk = txk;
            end
            `PSB_A_EQ: begin
               next_eq  = psb_eq_t'({i_hwdata[6:0], eq.hint, eq.coef});
               next_txk = i_hwdata[31:28];
            end
            `PSB_A_RXD: next_eq = psb_eq_t'({eq[27:21], i_hwdata[20:0]});
            default: next_txd = txd;
         endcase
      end
   end

   // read mux, address phase decoded for next-cycle data
   logic ap_take;
   assign ap_take = i_hsel && i_hready && i_htrans[1];
   always_comb begin
      next_ap_wr   = ap_take && i_hwrite;
      next_ap_addr = ap_take ? i_haddr[7:0] : 8'h00;
      next_hrdata  = o_hrdata;
      if (ap_take && !i_hwrite) begin
         case (i_haddr[7:0])
            `PSB_A_CTRL: next_hrdata = {3'h0, ctl, 8'h00, lanes_log2, bonded, mode};
            `PSB_A_TXD:  next_hrdata = txd;
            `PSB_A_EQ:   next_hrdata = {txk, 21'h0, eq[27:21]};
            `PSB_A_RXD:  next_hrdata = rxd;
            `PSB_A_STAT: next_hrdata = {rxk, 7'h00, sw_err, sw_st == PSB_SW_WAIT,
                                        lock_q, o_cal_busy, 4'h0, rs};
            `PSB_A_RATE: next_hrdata = {28'h0, done_q, o_rate_change_request};
            default:     next_hrdata = 32'h0;
         endcase
      end
   end

   // all state and outputs registered
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         mode <= PSB_G1_X1;
         bonded <= 1'b0;
         lanes_log2 <= 5'h0;
         txd <= '0;
         txk <= '0;
         ctl <= '0;
         eq <= '0;
         sw_st <= PSB_SW_IDLE;
         sw_target <= 2'h0;
         sw_err <= 1'b0;
         ap_wr <= 1'b0;
         ap_addr <= 8'h00;
         o_hrdata <= '0;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_tx_raw <= '0;
         o_rate_change_request <= 2'h0;
         o_cal_busy <= 1'b1;
         o_bond_clk_en <= 1'b0;
      end else begin
         mode <= next_mode;
         bonded <= next_bonded;
         lanes_log2 <= next_lanes_log2;
         txd <= next_txd;
         txk <= next_txk;
         ctl <= next_ctl;
         eq <= next_eq;
         sw_st <= next_sw_st;
         sw_target <= next_sw_target;
         sw_err <= next_sw_err;
         ap_wr <= next_ap_wr;
         ap_addr <= next_ap_addr;
         o_hrdata <= next_hrdata;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_tx_raw <= next_tx_raw;
         o_rate_change_request <= next_req;
         o_cal_busy <= pcal_q | tcal_q;
         o_bond_clk_en <= bonded && (lanes_log2 != 5'h0);
      end
   end

   // handshake and packing checks; only fields outside single-lane mapping are tested
   chk_rate_clear: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      sw_st == PSB_SW_WAIT && done_q == sw_target |=> o_rate_change_request == 2'h0)
      else $error("rate request not dropped");
   chk_pad_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      mode == PSB_G1_X1 |=> o_tx_raw[`PSB_TX_B1 +: 8] == '0 && !o_tx_raw[`PSB_TX_K1]
         && !o_tx_raw[`PSB_TX_DEEMPH] && o_tx_raw[`PSB_TX_DVALID:`PSB_TX_SYNC_LO] == '0
         && o_tx_raw[`PSB_TX_W-1:`PSB_TX_EQEVAL] == '0)
      else $error("unused bits driven");
   chk_bond_en: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !bonded |=> !o_bond_clk_en)
      else $error("bond bus enabled unbonded");
   chk_req_target: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      sw_st == PSB_SW_WAIT |-> o_rate_change_request == sw_target)
      else $error("rate request differs from target");
   chk_req_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      sw_st == PSB_SW_WAIT && done_q != sw_target |=> $stable(o_rate_change_request))
      else $error("rate request moved before done");
   chk_unbond_refuse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      sw_st == PSB_SW_IDLE && sw_go && !bonded |=> sw_err && sw_st == PSB_SW_IDLE)
      else $error("unbonded rate request accepted");
   cov_switch: cover property (@(posedge i_ref_clk) sw_st == PSB_SW_WAIT ##[1:50] sw_st == PSB_SW_IDLE);
   cov_g3: cover property (@(posedge i_ref_clk) mode == PSB_G3 && eq.eval);
   cov_err: cover property (@(posedge i_ref_clk) sw_err);
endmodule : psb_host

// ---- hw/psb_pkg.sv ----
// psb_pkg.sv: types of the sideband packer
// assumes psb_defines.svh is compiled alongside
package psb_pkg;
   typedef enum logic [1:0] {PSB_G1_X1, PSB_G12_X2, PSB_G3} psb_mode_t;
   // per-lane transmit control fields
   typedef struct packed {
      logic        compl;
      logic        eidle;
      logic        detlb;
      logic [1:0]  pwr;
      logic [2:0]  margin;
      logic        swing;
      logic        deemph;
      logic [1:0]  rate;
      logic        polar;
   } psb_txctl_t;
   // gen3 equalization fields
   typedef struct packed {
      logic [1:0]  sync;
      logic        blkst;
      logic        dvalid;
      logic        eval;
      logic        active;
      logic        oor;
      logic [2:0]  hint;
      logic [17:0] coef;
   } psb_eq_t;
   // decoded receive status
   typedef struct packed {
      logic [3:0]  sync_ok;
      logic        phy_status;
      logic        rx_valid;
      logic [2:0]  status;
      logic [1:0]  sync;
      logic        blkst;
      logic        dvalid;
   } psb_rxst_t;
   typedef enum logic [1:0] {PSB_SW_IDLE, PSB_SW_REQ, PSB_SW_WAIT} psb_sw_st_t;
endpackage : psb_pkg

// ---- tb/psb_dev_model.sv ----
// psb_dev_model.sv: channel and pll model facing the sideband packer
// assumes the bench sets the lane mapping and receive fields; one clock
`timescale 1ns/1ns
module psb_dev_model
   import psb_pkg::*;
(
   input  wire logic        i_ref_clk, // 25 MHz clock
   input  wire psb_mode_t   i_mode,    // lane mapping
   input  wire logic [31:0] i_rxd,     // rx bytes
   input  wire logic [3:0]  i_rxk,     // rx k flags
   input  wire psb_rxst_t   i_rxst,    // rx status fields
   input  wire logic [1:0]  i_req,     // rate request
   input  wire logic        i_slow,    // slow rate switch
   input  wire logic [2:0]  i_pll,     // lock, pll cal, tx cal
   output logic      [65:0] o_rx_raw,  // raw rx word
   output logic      [1:0]  o_done,    // rate switch done
   output logic      [2:0]  o_pll      // lock, pll cal, tx cal
);
   logic [1:0] last = 2'h0;
   logic [3:0] cnt = 4'h0;
   initial o_done = 2'h0;
   // unmapped bits sit high so the host must mask them; codes pass as given
   always_comb begin
      o_rx_raw = '1;
      o_rx_raw[8:0] = {i_rxk[0], i_rxd[7:0]};
      o_rx_raw[10] = i_rxst.sync_ok[0];
      o_rx_raw[36:32] = {i_rxst.status, i_rxst.rx_valid, i_rxst.phy_status};
      if (i_mode != PSB_G1_X1) begin
         o_rx_raw[23:15] = {i_rxk[1], i_rxd[15:8]};
         o_rx_raw[25] = i_rxst.sync_ok[1];
      end
      if (i_mode == PSB_G3) begin
         o_rx_raw[48:40] = {i_rxk[2], i_rxd[23:16]};
         o_rx_raw[63:55] = {i_rxk[3], i_rxd[31:24]};
         o_rx_raw[50] = i_rxst.sync_ok[2];
         o_rx_raw[65] = i_rxst.sync_ok[3];
         o_rx_raw[31:30] = i_rxst.sync;
         o_rx_raw[38:37] = {i_rxst.dvalid, i_rxst.blkst};
      end
   end
   // done follows a steady request after 3 or 13 cycles, never early
   // plain always: done also carries a power-up value from the initial block
   always @(posedge i_ref_clk) begin
      if (i_req !== last) begin
         last <= i_req;
         cnt <= 4'h0;
      end else if (cnt < (i_slow ? 4'hc : 4'h2)) begin
         cnt <= cnt + 4'h1;
      end else begin
         o_done <= last;
      end
   end
   // lock and calibration levels, high active
   assign o_pll = i_pll;
endmodule : psb_dev_model

// ---- tb/tb_psb_host.sv ----
// tb_psb_host.sv: self-checking bench for the sideband packer
// assumes psb_dev_model as far side and the packer as only ahb slave
`timescale 1ns/1ns
`include "psb_defines.svh"
module tb_psb_host
   import psb_pkg::*;
;
   typedef struct packed {
      psb_mode_t   m;
      psb_txctl_t  c;
      logic [31:0] d;
      logic [3:0]  k;
      psb_eq_t     e;
      logic [2:0]  st;
   } psb_row_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hsel = 1'b0;
   logic [2:0]  pll = 3'b011;
   psb_mode_t   mode = PSB_G1_X1;
   logic [31:0] rxd = 32'h0;
   logic [3:0]  rxk = 4'h0;
   psb_rxst_t   rxst = '0;
   logic        slow = 1'b0;
   logic [31:0] hrdata, q;
   logic [79:0] tx_raw;
   logic [65:0] rx_raw;
   logic [1:0]  req, done, tg;
   logic [2:0]  pll_o;
   logic [3:0]  mk;
   logic        hrdy, hresp, cal_busy, bond_en;
   psb_row_t    r;
   int          n;
   int          err_total = 0;
   int          samples_checked = 0;
   // coef literals are post, main and pre cursors from top down
   psb_row_t rows [8] = '{
      '{PSB_G1_X1,  13'h1fff, 32'ha5c3_e1f0, 4'hf, 28'hfff_ffff, 3'h0},
      '{PSB_G12_X2, 13'h1ff7, 32'h5a3c_1e0f, 4'he, 28'hfff_ffff, 3'h1},
      '{PSB_G3,     13'h0aaa, 32'h1234_5678, 4'h9, 28'h5a5_a5a5, 3'h2},
      '{PSB_G1_X1,  13'h0555, 32'hfedc_ba98, 4'h6, 28'ha5a_5a5a, 3'h3},
      '{PSB_G12_X2, 13'h0008, 32'h0f0f_f0f0, 4'h3, 28'h000_0000, 3'h4},
      '{PSB_G3,     13'h1fff, 32'hffff_ffff, 4'hf, 28'hfff_ffff, 3'h5},
      '{PSB_G3,     13'h0000, 32'h0000_0001, 4'h1, 28'h3f0_3f41, 3'h6},
      '{PSB_G12_X2, 13'h1555, 32'h8000_0000, 4'h8, 28'h0c0_0fc0, 3'h7}
   };
   psb_host i_psb_host (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hsel(hsel),
      .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
      .o_tx_raw(tx_raw), .i_rx_raw(rx_raw), .o_rate_change_request(req),
      .i_rate_change_complete_in(done), .i_pll_locked(pll_o[2]),
      .i_pll_cal_busy(pll_o[1]), .i_tx_cal_busy(pll_o[0]), .o_cal_busy(cal_busy),
      .o_bond_clk_en(bond_en));
   psb_dev_model i_psb_dev_model (
      .i_ref_clk(clk), .i_mode(mode), .i_rxd(rxd), .i_rxk(rxk), .i_rxst(rxst),
      .i_req(req), .i_slow(slow), .i_pll(pll), .o_rx_raw(rx_raw), .o_done(done),
      .o_pll(pll_o));
   // 40 ns period
   always #20 clk = ~clk;
   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // one single transfer; holds each phase until hready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus
   // expected raw transmit word from the lane mapping
   function automatic logic [79:0] exp_tx(input psb_row_t x);
      logic [79:0] t;
      t = '0;
      t[10:0] = {x.c.eidle, x.c.compl, x.k[0], x.d[7:0]};
      t[20] = x.c.detlb;
      t[27:21] = {x.c.swing, 1'b0, x.c.margin, x.c.pwr};
      t[34:32] = {x.c.polar, x.c.rate};
      if (x.m != PSB_G1_X1) t[19:11] = {x.k[1], x.d[15:8]};
      if (x.m == PSB_G12_X2) t[26] = x.c.deemph;
      if (x.m == PSB_G3) begin
         t[57:40] = {x.k[3], x.d[31:24], x.k[2], x.d[23:16]};
         t[31:28] = {x.e.dvalid, x.e.blkst, x.e.sync};
         t[37:35] = {x.e.oor, x.e.active, x.e.eval};
         t[78:58] = {x.e.coef, x.e.hint};
      end
      return t;
   endfunction : exp_tx
   // a hang would otherwise never reach the verdict
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      test_done();
   end
   // reset check, table loop, then rate switch and calibration cases
   initial begin
      repeat (16) @(posedge clk);
      chk({hrdy, hresp, req, cal_busy, bond_en}, 6'b10_0010);
      chk(tx_raw, 80'h0);
      rst_n <= 1'b1;
      pll <= 3'b000;
      foreach (rows[i]) begin
         r = rows[i];
         mk = (r.m == PSB_G1_X1) ? 4'h1 : (r.m == PSB_G12_X2) ? 4'h3 : 4'hf;
         mode <= r.m;
         rxd <= ~r.d;
         rxk <= ~r.k;
         rxst <= {r.k, 2'b11, r.st, r.e.sync, r.e.blkst, r.e.dvalid};
         bus(1'b1, `PSB_A_CTRL, {3'h0, r.c, 14'h0, r.m}, q);
         bus(1'b1, `PSB_A_TXD, r.d, q);
         bus(1'b1, `PSB_A_EQ, {r.k, 21'h0, r.e[27:21]}, q);
         bus(1'b1, `PSB_A_RXD, {11'h0, r.e[20:0]}, q);
         repeat (3) @(posedge clk);
         chk(tx_raw, exp_tx(r));
         chk(bond_en, 1'b0);
         bus(1'b0, `PSB_A_STAT, 32'h0, q);
         chk(q & 32'hf000_1fff, {~r.k & mk, 15'h0, r.k & mk, 2'b11, r.st,
             (r.m == PSB_G3) ? {r.e.sync, r.e.blkst, r.e.dvalid} : 4'h0});
         bus(1'b0, `PSB_A_RXD, 32'h0, q);
         chk(q, ~r.d & {{8{mk[3]}}, {8{mk[2]}}, {8{mk[1]}}, {8{mk[0]}}});
      end
      // bonded gen3 x2, a slow switch then a prompt one
      bus(1'b1, `PSB_A_CTRL, 32'h0000_000e, q);
      repeat (3) @(posedge clk);
      chk(bond_en, 1'b1);
      for (int t = 2; t > 0; t--) begin
         tg = 2'(t);
         slow <= (t == 2);
         bus(1'b1, `PSB_A_RATE, {30'h0, tg}, q);
         n = 0;
         while (req !== tg && n < 8) begin
            @(posedge clk);
            n++;
         end
         chk(req, tg);
         if (t == 2) begin
            repeat (6) @(posedge clk);
            chk(req, tg);
         end
         n = 0;
         while (req !== 2'h0 && n < 40) begin
            @(posedge clk);
            n++;
         end
         chk({req, done}, {2'h0, tg});
         repeat (30) @(posedge clk);
      end
      // unbonded request is refused and flagged
      bus(1'b1, `PSB_A_CTRL, 32'h0000_0002, q);
      bus(1'b1, `PSB_A_RATE, 32'h0000_0001, q);
      repeat (4) @(posedge clk);
      bus(1'b0, `PSB_A_STAT, 32'h0, q);
      chk({req, bond_en, q[20]}, 4'b0001);
      bus(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      // four lock and calibration busy combinations; lock tied to pll calibration busy
      for (int j = 0; j < 4; j++) begin
         pll <= {j[0], j[0], j[1]};
         repeat (6) @(posedge clk);
         chk(cal_busy, j[0] | j[1]);
         bus(1'b0, `PSB_A_STAT, 32'h0, q);
         chk(q[18:17], {j[0], j[0] | j[1]});
      end
      // mid-run reset clears the packed word, request and register state
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(tx_raw, 80'h0);
      chk({req, cal_busy, bond_en}, 4'b0010);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      bus(1'b0, `PSB_A_CTRL, 32'h0, q);
      chk(q, 32'h0);
      test_done();
   end
endmodule : tb_psb_host
